// [flash_spc_pkg.sv]
// Operation
// - table read returns one byte into latch
// - program 64-byte block or one 2-byte word
// - erase clears exactly one 1024-byte block
// - no bulk erase reachable from software
// - fetches stall while write or erase runs
// - internal timer ends every write and erase
// - any value programmable; invalid words execute NOP
// - program/data transfers pass 8-bit latch bytewise
// - table write fills holding registers only
// - table reads/writes work at any byte address
// - unlock key port stores nothing, reads zero
// - word select bit 5 picks 2 or 64
// - erase select bit 4; hardware clears after erase
// - write enable bit 2 gates writes; reset clear
// - abort flag set on start, cleared on finish
// - start bit 1 settable only; hardware clears
// - control bits 7, 6, 0 read zero
// - latch is 8-bit register holding moved byte
// - erase block from pointer bits 21 to 10
// - low pointer bits choose one of 64 holding
package flash_spc_pkg;

    // register indices; byte address is four times the index
    localparam logic [13:0] IDX_CONTROL = 14'hfa6;
    localparam logic [13:0] IDX_UNLOCK = 14'hfa7;
    localparam logic [13:0] IDX_LATCH = 14'hfa5;
    localparam logic [13:0] IDX_POINTER = 14'hfa8;
    localparam logic [13:0] IDX_TABLE_OP = 14'hfa9;
    localparam logic [13:0] IDX_STATUS = 14'hfaa;

    // control register field positions
    localparam int BIT_START = 1;
    localparam int BIT_PROGRAM_WRITE_ENABLE = 2;
    localparam int BIT_ABORT = 3;
    localparam int BIT_ERASE = 4;
    localparam int BIT_WORD = 5;

    // table operation command field positions
    localparam int BIT_OP_READ = 0;
    localparam int BIT_OP_WRITE = 1;
    localparam int BIT_OP_MODE = 2;

    // reset values
    localparam logic [7:0] RST_LATCH = 8'h00;
    localparam logic [21:0] RST_POINTER = 22'h000000;
    localparam logic [7:0] RST_HOLD = 8'hff;

    // unlock key sequence
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;

    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // timing
    localparam int CLK_HZ = 40000000;
    localparam int ERASE_TIME_US = 1000;
    localparam int WRITE_TIME_US = 500;

    typedef enum logic [1:0] {
        PTR_HOLD,
        PTR_POST_INC,
        PTR_POST_DEC,
        PTR_PRE_INC
    } ptr_mode_t;

    typedef enum logic {
        TMR_IDLE,
        TMR_RUN
    } timer_state_t;

endpackage

// [prog_if.sv]
`timescale 1ns/1ps
// start/done handshake between control logic and programming timer
interface prog_if;
    logic start;
    logic erase;
    logic done;
    logic busy;

    modport ctrl (output start, output erase, input done, input busy);
    modport timer (input start, input erase, output done, output busy);
endinterface

// [flash_prog_timer.sv]
`timescale 1ns/1ps
module flash_prog_timer #(
    parameter int unsigned ERASE_CYCLES = 40000,
    parameter int unsigned WRITE_CYCLES = 20000
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // handshake with control logic
    prog_if.timer pif
);

    flash_spc_pkg::timer_state_t state_reg;
    logic [31:0] count_reg;
    logic done_reg;

    assign pif.done = done_reg;
    assign pif.busy = (state_reg == flash_spc_pkg::TMR_RUN);

    // self-timed cycle; only expiry ends it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= flash_spc_pkg::TMR_IDLE;
            count_reg <= 32'h00000000;
            done_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            unique case (state_reg)
                flash_spc_pkg::TMR_IDLE: begin
                    if (pif.start) begin
                        state_reg <= flash_spc_pkg::TMR_RUN;
                        count_reg <= pif.erase ? ERASE_CYCLES - 32'h1
                                               : WRITE_CYCLES - 32'h1;
                    end
                end
                flash_spc_pkg::TMR_RUN: begin
                    if (count_reg == 32'h00000000) begin
                        state_reg <= flash_spc_pkg::TMR_IDLE;
                        done_reg <= 1'b1;
                    end else begin
                        count_reg <= count_reg - 32'h1;
                    end
                end
            endcase
        end
    end

    // done only ever closes a running cycle
    a_done_ends_run: assert property (@(posedge aclk) disable iff (!aresetn)
        done_reg |-> $past(state_reg) == flash_spc_pkg::TMR_RUN
                     && state_reg == flash_spc_pkg::TMR_IDLE)
        else $error("timer done without a running cycle");

endmodule

// [flash_self_program_control.sv]
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module flash_self_program_control #(
    parameter int unsigned ERASE_CYCLES =
        flash_spc_pkg::ERASE_TIME_US * (flash_spc_pkg::CLK_HZ / 1000000),
    parameter int unsigned WRITE_CYCLES =
        flash_spc_pkg::WRITE_TIME_US * (flash_spc_pkg::CLK_HZ / 1000000)
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [15:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [15:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // flash array read port
    output logic fa_rd_en,
    output logic [21:0] fa_addr,
    input wire logic [15:0] fa_rdata,
    // flash array programming port
    output logic fa_prog_en,
    output logic fa_erase_en,
    output logic fa_word_mode,
    output logic [11:0] fa_block_addr,
    output logic [4:0] fa_word_index,
    output logic [63:0][7:0] fa_hold_data,
    // core fetch stall
    output logic fetch_stall
);

    // bus channel state
    logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic aw_hold_reg, w_hold_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;
    logic [13:0] wr_idx_reg, rd_idx_reg;
    logic [31:0] wdata_reg;
    logic wlane_reg;
    logic wr_fire;

    // control register and sequencing state
    logic program_write_enable_reg, erase_sel_reg, word_sel_reg, start_reg, abort_reg;
    logic key_half_reg, armed_reg;
    logic prog_en_reg, erase_en_reg, word_mode_reg, stall_reg;
    logic [11:0] block_reg;
    logic [4:0] word_idx_reg;

    // table access state
    logic [7:0] latch_reg;
    logic [21:0] ptr_reg, fa_addr_reg;
    logic [63:0][7:0] hold_reg;
    logic rd_en_reg, rd_pend_reg;

    // decoded write commands
    logic ctl_wr, key_wr, start_req, start_ok, op_wr, op_read, op_write;
    flash_spc_pkg::ptr_mode_t op_mode;
    logic [21:0] op_addr;

    prog_if pif_i ();

    flash_prog_timer #(
        .ERASE_CYCLES(ERASE_CYCLES),
        .WRITE_CYCLES(WRITE_CYCLES)
    ) u_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .pif(pif_i.timer)
    );

    // step the low 21 pointer bits; the top bit is never carried into
    function automatic logic [21:0] ptr_step(input logic [21:0] p,
                                             input logic up);
        ptr_step = {p[21], up ? p[20:0] + 21'h1 : p[20:0] - 21'h1};
    endfunction

    function automatic logic is_mapped(input logic [13:0] idx);
        is_mapped = idx == flash_spc_pkg::IDX_CONTROL
                 || idx == flash_spc_pkg::IDX_UNLOCK
                 || idx == flash_spc_pkg::IDX_LATCH
                 || idx == flash_spc_pkg::IDX_POINTER
                 || idx == flash_spc_pkg::IDX_TABLE_OP
                 || idx == flash_spc_pkg::IDX_STATUS;
    endfunction

    // outputs straight from flops
    assign awready = awready_reg;
    assign wready = wready_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign arready = arready_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;
    assign fa_rd_en = rd_en_reg;
    assign fa_addr = fa_addr_reg;
    assign fa_prog_en = prog_en_reg;
    assign fa_erase_en = erase_en_reg;
    assign fa_word_mode = word_mode_reg;
    assign fa_block_addr = block_reg;
    assign fa_word_index = word_idx_reg;
    assign fa_hold_data = hold_reg;
    assign fetch_stall = stall_reg;

    // write decode; registers sit in byte lane 0
    assign wr_fire = aw_hold_reg & w_hold_reg & ~bvalid_reg;
    assign ctl_wr = wr_fire & wlane_reg
                  & (wr_idx_reg == flash_spc_pkg::IDX_CONTROL);
    assign key_wr = wr_fire & wlane_reg
                  & (wr_idx_reg == flash_spc_pkg::IDX_UNLOCK);
    assign op_wr = wr_fire & wlane_reg & ~stall_reg
                 & (wr_idx_reg == flash_spc_pkg::IDX_TABLE_OP);
    assign op_read = op_wr & wdata_reg[flash_spc_pkg::BIT_OP_READ];
    assign op_write = op_wr & wdata_reg[flash_spc_pkg::BIT_OP_WRITE];
    assign op_mode = flash_spc_pkg::ptr_mode_t'(
        wdata_reg[flash_spc_pkg::BIT_OP_MODE +: 2]);
    assign op_addr = (op_mode == flash_spc_pkg::PTR_PRE_INC)
                   ? ptr_step(ptr_reg, 1'b1) : ptr_reg;
    // zero written to start is ignored; one is a start request unless start is already set
    assign start_req = ctl_wr & wdata_reg[flash_spc_pkg::BIT_START]
                     & ~start_reg;
    assign start_ok = start_req & armed_reg
                    & wdata_reg[flash_spc_pkg::BIT_PROGRAM_WRITE_ENABLE]
                    & program_write_enable_reg;

    // write address and data channels, taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            wr_idx_reg <= 14'h0000;
            wdata_reg <= 32'h00000000;
            wlane_reg <= 1'b0;
        end else begin
            if (awvalid && awready_reg) begin
                awready_reg <= 1'b0;
                aw_hold_reg <= 1'b1;
                wr_idx_reg <= awaddr[15:2];
            end
            if (wvalid && wready_reg) begin
                wready_reg <= 1'b0;
                w_hold_reg <= 1'b1;
                wdata_reg <= wdata;
                wlane_reg <= wstrb[0];
            end
            if (wr_fire) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg <= 1'b0;
            end
            if (bvalid_reg && bready) begin
                awready_reg <= 1'b1;
                wready_reg <= 1'b1;
            end
        end
    end

    // write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= flash_spc_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= is_mapped(wr_idx_reg) ? flash_spc_pkg::RESP_OKAY
                                               : flash_spc_pkg::RESP_SLVERR;
        end else if (bvalid_reg && bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // read channel; key port has no storage and reads zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= flash_spc_pkg::RESP_OKAY;
            rd_idx_reg <= 14'h0000;
        end else if (arvalid && arready_reg) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rd_idx_reg <= araddr[15:2];
            rresp_reg <= is_mapped(araddr[15:2]) ? flash_spc_pkg::RESP_OKAY
                                                 : flash_spc_pkg::RESP_SLVERR;
            unique case (araddr[15:2])
                flash_spc_pkg::IDX_CONTROL:
                    rdata_reg <= {26'h0000000, word_sel_reg, erase_sel_reg,
                                  abort_reg, program_write_enable_reg, start_reg,
                                  1'b0};
                flash_spc_pkg::IDX_LATCH:
                    rdata_reg <= {24'h000000, latch_reg};
                flash_spc_pkg::IDX_POINTER:
                    rdata_reg <= {10'h000, ptr_reg};
                flash_spc_pkg::IDX_STATUS:
                    rdata_reg <= {30'h00000000, armed_reg, stall_reg};
                default:
                    rdata_reg <= 32'h00000000;
            endcase
        end else if (rvalid_reg && rready) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
        end
    end

    // unlock: 55h then 0aah arms one start; any other write except a control write without start disarms
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            key_half_reg <= 1'b0;
            armed_reg <= 1'b0;
        end else if (key_wr) begin
            key_half_reg <= wdata_reg[7:0] == flash_spc_pkg::KEY_FIRST;
            armed_reg <= key_half_reg
                       && wdata_reg[7:0] == flash_spc_pkg::KEY_SECOND;
        end else if (wr_fire && !(wr_idx_reg == flash_spc_pkg::IDX_CONTROL
                                  && !start_req)) begin
            key_half_reg <= 1'b0;
            armed_reg <= 1'b0;
        end
    end

    // software-writable control bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            program_write_enable_reg <= 1'b0;
            word_sel_reg <= 1'b0;
            erase_sel_reg <= 1'b0;
        end else begin
            if (ctl_wr && !stall_reg) begin
                program_write_enable_reg <= wdata_reg[flash_spc_pkg::BIT_PROGRAM_WRITE_ENABLE];
                word_sel_reg <= wdata_reg[flash_spc_pkg::BIT_WORD];
                erase_sel_reg <= wdata_reg[flash_spc_pkg::BIT_ERASE];
            end
            if (pif_i.done && erase_en_reg) begin
                erase_sel_reg <= 1'b0;
            end
        end
    end

    // start bit: set only by an accepted start, cleared by the timer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_reg <= 1'b0;
        end else if (start_ok) begin
            start_reg <= 1'b1;
        end else if (pif_i.done) begin
            start_reg <= 1'b0;
        end
    end

    // abort flag: any start request sets it, normal expiry clears it;
    // a reset mid-operation leaves it set
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            if (stall_reg || abort_reg) begin
                abort_reg <= 1'b1;
            end else begin
                abort_reg <= 1'b0;
            end
        end else if (start_req) begin
            abort_reg <= 1'b1;
        end else if (pif_i.done) begin
            abort_reg <= 1'b0;
        end else if (ctl_wr) begin
            abort_reg <= wdata_reg[flash_spc_pkg::BIT_ABORT];
        end
    end

    // array operation drive; only block erase or program exists
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prog_en_reg <= 1'b0;
            erase_en_reg <= 1'b0;
            word_mode_reg <= 1'b0;
            stall_reg <= 1'b0;
            block_reg <= 12'h000;
            word_idx_reg <= 5'h00;
        end else if (start_ok) begin
            erase_en_reg <= erase_sel_reg;
            prog_en_reg <= ~erase_sel_reg;
            word_mode_reg <= word_sel_reg;
            block_reg <= ptr_reg[21:10];
            word_idx_reg <= ptr_reg[5:1];
            stall_reg <= 1'b1;
        end else if (pif_i.done) begin
            prog_en_reg <= 1'b0;
            erase_en_reg <= 1'b0;
            stall_reg <= 1'b0;
        end
    end

    assign pif_i.start = start_ok & ~pif_i.busy;
    assign pif_i.erase = erase_sel_reg;

    // table pointer: direct writes and table-op stepping
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ptr_reg <= flash_spc_pkg::RST_POINTER;
        end else if (op_wr) begin
            unique case (op_mode)
                flash_spc_pkg::PTR_HOLD: ptr_reg <= ptr_reg;
                flash_spc_pkg::PTR_POST_DEC:
                    ptr_reg <= ptr_step(ptr_reg, 1'b0);
                flash_spc_pkg::PTR_POST_INC,
                flash_spc_pkg::PTR_PRE_INC:
                    ptr_reg <= ptr_step(ptr_reg, 1'b1);
            endcase
        end else if (wr_fire && wlane_reg && !stall_reg
                     && wr_idx_reg == flash_spc_pkg::IDX_POINTER) begin
            ptr_reg <= wdata_reg[21:0];
        end
    end

    // table read: array read strobe, byte picked by address bit 0
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_en_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            fa_addr_reg <= flash_spc_pkg::RST_POINTER;
        end else begin
            rd_en_reg <= op_read;
            rd_pend_reg <= rd_en_reg;
            if (op_read) begin
                fa_addr_reg <= op_addr;
            end
        end
    end

    // byte latch between the two memory widths
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            latch_reg <= flash_spc_pkg::RST_LATCH;
        end else if (rd_pend_reg) begin
            latch_reg <= fa_addr_reg[0] ? fa_rdata[15:8]
                                        : fa_rdata[7:0];
        end else if (wr_fire && wlane_reg
                     && wr_idx_reg == flash_spc_pkg::IDX_LATCH) begin
            latch_reg <= wdata_reg[7:0];
        end
    end

    // table write: latch byte into holding registers, never the array;
    // no check on content, any byte is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hold_reg <= {64{flash_spc_pkg::RST_HOLD}};
        end else if (op_write && !op_read) begin
            hold_reg[op_addr[5:0]] <= latch_reg;
        end
    end

    // checks

    a_start_needs_key: assert property (@(posedge aclk)
        disable iff (!aresetn)
        $rose(start_reg) |-> $past(armed_reg) && $past(program_write_enable_reg)
                             && abort_reg)
        else $error("start accepted without unlock and enable");

    a_stall_while_busy: assert property (@(posedge aclk)
        disable iff (!aresetn)
        stall_reg == (prog_en_reg | erase_en_reg)
        && (stall_reg == start_reg))
        else $error("fetch stall does not match operation");

    a_erase_sel_clear: assert property (@(posedge aclk)
        disable iff (!aresetn)
        pif_i.done && erase_en_reg |=> !erase_sel_reg && !start_reg)
        else $error("erase select kept after erase");

    a_abort_on_start: assert property (@(posedge aclk)
        disable iff (!aresetn)
        start_req |=> abort_reg)
        else $error("abort flag not set by start");

    a_abort_on_done: assert property (@(posedge aclk)
        disable iff (!aresetn)
        pif_i.done |=> !abort_reg && !start_reg)
        else $error("abort flag or start left after finish");

    a_key_reads_zero: assert property (@(posedge aclk)
        disable iff (!aresetn)
        rvalid_reg && rd_idx_reg == flash_spc_pkg::IDX_UNLOCK
        |-> rdata_reg == 32'h00000000)
        else $error("unlock key port read nonzero");

    a_ctl_unused_zero: assert property (@(posedge aclk)
        disable iff (!aresetn)
        rvalid_reg && rd_idx_reg == flash_spc_pkg::IDX_CONTROL
        |-> rdata_reg[31:6] == 26'h0000000 && !rdata_reg[0])
        else $error("unimplemented control bits read nonzero");

    a_read_fills_latch: assert property (@(posedge aclk)
        disable iff (!aresetn)
        op_read |-> ##3 latch_reg == ($past(fa_addr_reg[0])
                     ? $past(fa_rdata[15:8]) : $past(fa_rdata[7:0])))
        else $error("table read byte not in latch");

    a_erase_block_sel: assert property (@(posedge aclk)
        disable iff (!aresetn)
        start_ok && erase_sel_reg |=> erase_en_reg && !prog_en_reg
        && block_reg == $past(ptr_reg[21:10]))
        else $error("erase block not taken from pointer");

    a_no_program_write_enable_no_op: assert property (@(posedge aclk)
        disable iff (!aresetn)
        start_req && !program_write_enable_reg |=> !prog_en_reg && !erase_en_reg)
        else $error("array operation without write enable");

endmodule

// [flash_array_model.sv]
`timescale 1ns/1ps
// flash array read port: word valid the cycle after a strobe
module flash_array_model (
    // clock
    input wire logic aclk,
    // read port
    input wire logic rd_en,
    input wire logic [21:0] addr,
    output logic [15:0] rdata
);
    // each byte holds its own address low byte; the bus toggles
    // between reads so stale data never looks like a fresh word
    initial rdata = 16'h0000;
    always @(posedge aclk) begin
        if (rd_en) begin
            rdata <= {addr[7:1], 1'b1, addr[7:1], 1'b0};
        end else begin
            rdata <= ~rdata;
        end
    end
endmodule

// [flash_self_program_control_test.sv]
`timescale 1ns/1ps
module flash_self_program_control_test;
    localparam int EC = 40;
    localparam int WC = 20;
    localparam logic [15:0] A_CTL = {flash_spc_pkg::IDX_CONTROL, 2'b00};
    localparam logic [15:0] A_KEY = {flash_spc_pkg::IDX_UNLOCK, 2'b00};
    localparam logic [15:0] A_LAT = {flash_spc_pkg::IDX_LATCH, 2'b00};
    localparam logic [15:0] A_PTR = {flash_spc_pkg::IDX_POINTER, 2'b00};
    localparam logic [15:0] A_OP = {flash_spc_pkg::IDX_TABLE_OP, 2'b00};
    localparam logic [15:0] A_STA = {flash_spc_pkg::IDX_STATUS, 2'b00};
    localparam logic [1:0] OK = flash_spc_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = flash_spc_pkg::RESP_SLVERR;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
    logic bready, arvalid, arready, rvalid, rready;
    logic [15:0] awaddr, araddr, fa_rdata;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic fa_rd_en, fa_prog_en, fa_erase_en, fa_word_mode, fetch_stall;
    logic [21:0] fa_addr;
    logic [11:0] fa_block_addr;
    logic [4:0] fa_word_index;
    logic [63:0][7:0] fa_hold_data;
    int n_errors = 0;
    int num_checks = 0;

    // block under test and the array beside it
    flash_self_program_control #(.ERASE_CYCLES(EC), .WRITE_CYCLES(WC))
        i_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .fa_rd_en,
        .fa_addr, .fa_rdata, .fa_prog_en, .fa_erase_en, .fa_word_mode,
        .fa_block_addr, .fa_word_index, .fa_hold_data, .fetch_stall);
    flash_array_model i_flash (.aclk, .rd_en(fa_rd_en), .addr(fa_addr),
        .rdata(fa_rdata));

    // 40 MHz clock
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time,
                got, exp);
        end
    endtask

    // bus write: hold each channel until taken, wait for the answer
    task automatic wr(input logic [15:0] a, input logic [31:0] d,
        input logic [1:0] er);
        int n;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 100) begin
            n_errors++;
            wrap_up();
        end
        chk(bresp, er);
    endtask

    // bus read compared against an expected word and response
    task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp,
        input logic [1:0] er);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (n == 100) begin
            n_errors++;
            wrap_up();
        end
        chk(rdata, exp);
        chk(rresp, er);
    endtask

    // register map, reset values and unimplemented bits
    task automatic t_regs();
        rd_chk(A_CTL, 32'h0, OK);
        wr(A_CTL, 32'h000000e5, OK);
        rd_chk(A_CTL, 32'h00000024, OK);
        wr(A_KEY, 32'h00000055, OK);
        rd_chk(A_KEY, 32'h0, OK);
        wr(16'h0000, 32'h0, ERR);
        rd_chk(16'h0000, 32'h0, ERR);
        wr(A_LAT, 32'h000000a5, OK);
        rd_chk(A_LAT, 32'h000000a5, OK);
    endtask

    // one table read: latch byte and pointer afterwards
    task automatic t_tread(input logic [3:0] op, input logic [7:0] lat,
        input logic [21:0] ptr);
        wr(A_OP, {28'h0, op}, OK);
        @(posedge aclk); // latch loads three edges after the op
        rd_chk(A_LAT, {24'h0, lat}, OK);
        rd_chk(A_PTR, {10'h0, ptr}, OK);
    endtask

    // one start attempt, with or without the unlock keys
    task automatic t_prog(input logic [7:0] mode, input logic [21:0] p,
        input logic key);
        logic ok;
        int n;
        ok = key & mode[2];
        wr(A_PTR, {10'h0, p}, OK);
        wr(A_CTL, {24'h0, mode}, OK);
        if (key) begin
            wr(A_KEY, 32'h00000055, OK);
            wr(A_KEY, 32'h000000aa, OK);
        end
        wr(A_CTL, {24'h0, mode | 8'h02}, OK);
        @(posedge aclk);
        chk(fetch_stall, ok);
        chk({fa_erase_en, fa_prog_en}, ok ? {mode[4], ~mode[4]} : 2'b00);
        if (ok) begin
            chk({fa_block_addr, fa_word_mode, fa_word_index},
                {p[21:10], mode[5], p[5:1]});
        end
        rd_chk(A_CTL, mode | (ok ? 8'h0a : 8'h08), OK);
        for (n = 0; n < 4 * EC; n++) begin
            @(posedge aclk);
            if (fetch_stall === 1'b0) break;
        end
        if (n == 4 * EC) begin
            n_errors++;
            wrap_up();
        end
        rd_chk(A_CTL, ok ? mode & 8'hec : mode | 8'h08, OK);
    endtask

    // reset cut into a running write leaves the abort flag up
    task automatic t_cut();
        wr(A_CTL, 32'h00000004, OK);
        wr(A_KEY, 32'h00000055, OK);
        wr(A_KEY, 32'h000000aa, OK);
        wr(A_CTL, 32'h00000006, OK);
        rd_chk(A_STA, 32'h00000001, OK);
        aresetn <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd_chk(A_CTL, 32'h00000008, OK);
        chk(fetch_stall, 1'b0);
    endtask

    // main sequence
    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata} = 64'h0;
        wstrb = 4'hf;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        wr(A_PTR, 32'h00000103, OK);
        t_tread(4'h5, 8'h03, 22'h000104);
        t_tread(4'hd, 8'h05, 22'h000105);
        t_tread(4'h9, 8'h05, 22'h000104);
        t_tread(4'h1, 8'h04, 22'h000104);
        wr(A_LAT, 32'h0000003c, OK);
        wr(A_PTR, 32'h0000006a, OK);
        wr(A_OP, 32'h00000002, OK);
        @(posedge aclk);
        chk(fa_hold_data[42], 8'h3c);
        chk(fa_prog_en, 1'b0);
        t_prog(8'h04, 22'h2ab46, 1'b0);
        t_prog(8'h20, 22'h2ab46, 1'b1);
        t_prog(8'h04, 22'h2ab46, 1'b1);
        t_prog(8'h24, 22'h01c0b, 1'b1);
        t_prog(8'h14, 22'h3ff80, 1'b1);
        t_cut();
        wrap_up();
    end
endmodule
